// ==== tbpm_host_model.sv ====
`timescale 1ns/1ps
// Host controller model: it issues register accesses over AXI4-Lite.
module tbpm_host_model (
	input wire logic aclk,
	output logic awvalid,
	input wire logic awready,
	output logic [7:0] awaddr,
	output logic [2:0] awprot,
	output logic wvalid,
	input wire logic wready,
	output logic [31:0] wdata,
	output logic [3:0] wstrb,
	input wire logic bvalid,
	output logic bready,
	input wire logic [1:0] bresp,
	output logic arvalid,
	input wire logic arready,
	output logic [7:0] araddr,
	output logic [2:0] arprot,
	input wire logic rvalid,
	output logic rready,
	input wire logic [31:0] rdata,
	input wire logic [1:0] rresp
);
	int tmo = 0; // Accesses that got no answer in time.
	int lag = 0; // Cycles before the host accepts an answer, to act slowly.
	logic [3:0] strb = 4'hf; // Byte strobes of the next write.
	// Everything idle at time zero.
	initial begin
		{awvalid, wvalid, bready, arvalid, rready} = '0;
		{awaddr, araddr, awprot, arprot, wstrb, wdata} = '0;
	end
	// One write; address and data are offered together and each is held until taken.
	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		awaddr <= a;
		wdata <= d;
		wstrb <= strb;
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (awready) awvalid <= 1'b0;
			if (wready) wvalid <= 1'b0;
			if (n >= lag) bready <= 1'b1;
		end while (!(bvalid && bready) && n < 300);
		bready <= 1'b0;
		r = bresp;
		if (n >= 300) tmo++;
	endtask : wr
	// One read; the address is held until taken, rready until data come.
	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		n = 0;
		@(posedge aclk);
		araddr <= a;
		arvalid <= 1'b1;
		do begin
			@(posedge aclk);
			n++;
			if (arready) arvalid <= 1'b0;
			if (n >= lag) rready <= 1'b1;
		end while (!(rvalid && rready) && n < 300);
		rready <= 1'b0;
		d = rdata;
		r = rresp;
		if (n >= 300) tmo++;
	endtask : rd
endmodule : tbpm_host_model

// ==== tbpm_pkg.sv ====
// Shared constants for the bias power-mode controller.
package tbpm_pkg;
	// Channel and field widths.
	localparam int NUM_OUTPUTS = 6;
	localparam int CODE_W = 7;
	localparam int BOOST_W = 4;
	localparam int MODE_W = 2;
	localparam int ADDR_W = 8;
	// Register byte addresses.
	localparam logic [7:0] ADDR_MODE = 8'h00;
	localparam logic [7:0] ADDR_BOOST = 8'h04;
	localparam logic [7:0] ADDR_ENABLE = 8'h08;
	localparam logic [7:0] ADDR_CODE0 = 8'h0c;
	localparam logic [7:0] ADDR_STATUS = 8'h24;
	// Field positions inside the status word.
	localparam int STATUS_IO_POS = 2;
	localparam int STATUS_ANALOG_POS = 3;
	// Reset values applied in shutdown and startup.
	localparam logic [3:0] RST_BOOST = 4'hb;
	localparam logic [5:0] RST_ENABLE = 6'h00;
	localparam logic [6:0] RST_CODE = 7'h00;
	localparam logic [6:0] CODE_MAX = 7'h7f;
	// Power state command and status codes.
	localparam logic [1:0] CMD_ACTIVE = 2'h0;
	localparam logic [1:0] CMD_STARTUP = 2'h1;
	localparam logic [1:0] CMD_LOW_POWER = 2'h2;
	localparam logic [1:0] CODE_SHUTDOWN = 2'h3;
	// Boosted rail scale in volts.
	localparam logic [4:0] BOOST_MIN_V = 5'h0d;
	localparam logic [4:0] BOOST_STEP_V = 5'h01;
	// Output step in millivolts.
	localparam int OUT_STEP_MV = 188;
	// Startup duration and its cycle count.
	localparam int CLK_PERIOD_NS = 100;
	localparam int STARTUP_TIME_NS = 180000;
	localparam int STARTUP_CYCLES = (STARTUP_TIME_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	// AXI responses.
	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;
	// Power modes.
	typedef enum logic [1:0] {MODE_SHUTDOWN, MODE_STARTUP, MODE_ACTIVE, MODE_LOW_POWER} tbpm_mode_t;
endpackage : tbpm_pkg

// ==== tbpm_power_ctrl.sv ====
// Function
// - Shutdown at analog power-up or io supply low.
// - Shutdown: everything off, outputs high impedance.
// - Registers are lost through shutdown.
// - Io supply high moves shutdown to startup once the analog supply is also up.
// - Startup resets registers, boost on, outputs off.
// - Startup command accepted from active or low power.
// - Startup ends in active mode by itself.
// - Active: blocks on, outputs need their enable.
// - Outputs programmed and disabled independently, live.
// - Active command returns low power to active.
// - Low power command accepted only from active.
// - Low power: bus on, boost off, outputs off.
// - Low power keeps all register contents.
// - Boost code four bits, 13 V plus volts.
// - Boost code defaults to the 24 V value.
// - Output code has 128 steps of 188 mV.
// - Largest output code is 7Fh.
// - Code zero and disabled output pulls down.
// - Mode field reads startup, then active.
`timescale 1ns/1ps
module tbpm_power_ctrl #(
	parameter int STARTUP_LEN = tbpm_pkg::STARTUP_CYCLES
) (
	input wire logic aclk,
	input wire logic aresetn,
	input wire logic clk_en,
	input wire logic analog_supply,
	input wire logic io_supply,
	input wire logic awvalid,
	output logic awready,
	input wire logic [tbpm_pkg::ADDR_W-1:0] awaddr,
	input wire logic [2:0] awprot,
	input wire logic wvalid,
	output logic wready,
	input wire logic [31:0] wdata,
	input wire logic [3:0] wstrb,
	output logic bvalid,
	input wire logic bready,
	output logic [1:0] bresp,
	input wire logic arvalid,
	output logic arready,
	input wire logic [tbpm_pkg::ADDR_W-1:0] araddr,
	input wire logic [2:0] arprot,
	output logic rvalid,
	input wire logic rready,
	output logic [31:0] rdata,
	output logic [1:0] rresp,
	output logic [tbpm_pkg::MODE_W-1:0] power_state_command,
	output logic serial_enable,
	output logic boost_enable,
	output logic [tbpm_pkg::BOOST_W-1:0] boost_code,
	output logic [4:0] boosted_rail_volts,
	output logic [tbpm_pkg::NUM_OUTPUTS-1:0] out_drive,
	output logic [tbpm_pkg::NUM_OUTPUTS-1:0] out_pulldown,
	output logic [tbpm_pkg::NUM_OUTPUTS*tbpm_pkg::CODE_W-1:0] out_code
);
	import tbpm_pkg::*;

	localparam int CNT_W = $clog2(STARTUP_LEN + 1);

	// The startup counter cannot serve a zero length.
	if (STARTUP_LEN < 1) begin : g_bad_len
		$error("STARTUP_LEN must be at least one cycle.");
	end

	logic [2:0] io_sync_q; // Io supply synchroniser chain.
	logic [2:0] an_sync_q; // Analog supply synchroniser chain.
	logic io_lvl_q; // Filtered io supply level.
	logic an_lvl_q; // Filtered analog supply level.
	tbpm_mode_t mode_q; // Current power mode.
	logic [CNT_W-1:0] cnt_q; // Startup cycle counter.
	logic [BOOST_W-1:0] boost_q; // Boost level code.
	logic [NUM_OUTPUTS-1:0] enable_q; // Per-output enables.
	logic [CODE_W-1:0] code_q [NUM_OUTPUTS]; // Per-output codes.
	logic [ADDR_W-1:0] awaddr_q; // Held write address.
	logic [31:0] wdata_q; // Held write data.
	logic wstrb0_q; // Held low byte lane strobe.
	logic awready_q; // Write address ready.
	logic wready_q; // Write data ready.
	logic bvalid_q; // Write response valid.
	logic [1:0] bresp_q; // Write response code.
	logic arready_q; // Read address ready.
	logic rvalid_q; // Read data valid.
	logic [31:0] rdata_q; // Read data.
	logic [1:0] rresp_q; // Read response code.
	logic [MODE_W-1:0] mode_code_q; // Mode as software sees it.
	logic serial_en_q; // Serial interface enable.
	logic boost_en_q; // Boost converter enable.
	logic [4:0] rail_q; // Boosted rail target in volts.
	logic [NUM_OUTPUTS-1:0] drive_q; // Output drivers on.
	logic [NUM_OUTPUTS-1:0] pulldown_q; // Output pull-downs on.
	logic [NUM_OUTPUTS*CODE_W-1:0] code_out_q; // Codes to the output stages.
	logic supplies_ok; // Both supplies present.
	logic wr_fire; // A write is carried out this cycle.
	logic cmd_wr; // A power state command arrives.
	logic set_wr; // Setting registers may be written.
	logic hold_defaults; // Settings forced to defaults.
	logic [31:0] rd_word; // Read mux result.
	logic rd_hit; // Read address is mapped.
	logic wr_hit; // Write address is mapped.

	assign supplies_ok = io_lvl_q & an_lvl_q;
	assign wr_fire = ~awready_q & ~wready_q & ~bvalid_q;
	assign cmd_wr = wr_fire & wstrb0_q & (awaddr_q == ADDR_MODE);
	assign set_wr = wr_fire & wstrb0_q & (mode_q == MODE_ACTIVE);
	assign hold_defaults = (mode_q == MODE_SHUTDOWN) | (mode_q == MODE_STARTUP);

	// Supply pins pass three flops; a level counts once the last two agree.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			io_sync_q <= 3'h0;
			an_sync_q <= 3'h0;
			io_lvl_q <= 1'b0;
			an_lvl_q <= 1'b0;
		end else if (clk_en) begin
			io_sync_q <= {io_sync_q[1:0], io_supply};
			an_sync_q <= {an_sync_q[1:0], analog_supply};
			if (io_sync_q[1] == io_sync_q[2]) begin
				io_lvl_q <= io_sync_q[2];
			end
			if (an_sync_q[1] == an_sync_q[2]) begin
				an_lvl_q <= an_sync_q[2];
			end
		end
	end

	// Power mode sequencer.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_q <= MODE_SHUTDOWN;
			cnt_q <= '0;
		end else if (clk_en) begin
			if (!supplies_ok) begin
				// Losing either supply forces shutdown from any mode.
				mode_q <= MODE_SHUTDOWN;
				cnt_q <= '0;
			end else begin
				case (mode_q)
					MODE_SHUTDOWN: begin
						mode_q <= MODE_STARTUP;
						cnt_q <= '0;
					end
					MODE_STARTUP: begin
						// Commands during startup are ignored.
						if (cnt_q == CNT_W'(STARTUP_LEN - 1)) begin
							mode_q <= MODE_ACTIVE;
						end else begin
							cnt_q <= cnt_q + 1'b1;
						end
					end
					MODE_ACTIVE: begin
						if (cmd_wr && wdata_q[1:0] == CMD_STARTUP) begin
							mode_q <= MODE_STARTUP;
							cnt_q <= '0;
						end else if (cmd_wr && wdata_q[1:0] == CMD_LOW_POWER) begin
							mode_q <= MODE_LOW_POWER;
						end
					end
					MODE_LOW_POWER: begin
						if (cmd_wr && wdata_q[1:0] == CMD_STARTUP) begin
							mode_q <= MODE_STARTUP;
							cnt_q <= '0;
						end else if (cmd_wr && wdata_q[1:0] == CMD_ACTIVE) begin
							mode_q <= MODE_ACTIVE;
						end
						// Any other code leaves the mode as it is.
					end
					default: begin
						mode_q <= MODE_SHUTDOWN;
					end
				endcase
			end
		end
	end

	// Boost code and enables; defaults in shutdown and startup.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			boost_q <= RST_BOOST;
			enable_q <= RST_ENABLE;
		end else if (clk_en) begin
			if (hold_defaults) begin
				boost_q <= RST_BOOST;
				enable_q <= RST_ENABLE;
			end else if (set_wr && awaddr_q == ADDR_BOOST) begin
				boost_q <= wdata_q[BOOST_W-1:0];
			end else if (set_wr && awaddr_q == ADDR_ENABLE) begin
				enable_q <= wdata_q[NUM_OUTPUTS-1:0];
			end
		end
	end

	// One code register and one output stage per channel.
	for (genvar i = 0; i < NUM_OUTPUTS; i++) begin : g_out
		localparam logic [7:0] ADDR_I = ADDR_CODE0 + 8'(4 * i);
		always_ff @(posedge aclk) begin
			if (!aresetn) begin
				code_q[i] <= RST_CODE;
				drive_q[i] <= 1'b0;
				pulldown_q[i] <= 1'b0;
				code_out_q[i*CODE_W +: CODE_W] <= RST_CODE;
			end else if (clk_en) begin
				if (hold_defaults) begin
					code_q[i] <= RST_CODE;
				end else if (set_wr && awaddr_q == ADDR_I) begin
					// Seven bits give 128 steps, top code CODE_MAX.
					code_q[i] <= wdata_q[CODE_W-1:0] & CODE_MAX;
				end
				// Only active mode may drive; elsewhere the pin floats.
				drive_q[i] <= (mode_q == MODE_ACTIVE) & enable_q[i];
				pulldown_q[i] <= (mode_q == MODE_ACTIVE) & ~enable_q[i]
					& (code_q[i] == RST_CODE);
				code_out_q[i*CODE_W +: CODE_W] <= code_q[i];
			end
		end
	end

	// Mode status, supply enables and rail target.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			mode_code_q <= CODE_SHUTDOWN;
			serial_en_q <= 1'b0;
			boost_en_q <= 1'b0;
			rail_q <= BOOST_MIN_V;
		end else if (clk_en) begin
			case (mode_q)
				MODE_STARTUP: mode_code_q <= CMD_STARTUP;
				MODE_ACTIVE: mode_code_q <= CMD_ACTIVE;
				MODE_LOW_POWER: mode_code_q <= CMD_LOW_POWER;
				default: mode_code_q <= CODE_SHUTDOWN;
			endcase
			serial_en_q <= (mode_q != MODE_SHUTDOWN);
			boost_en_q <= (mode_q == MODE_STARTUP) | (mode_q == MODE_ACTIVE);
			rail_q <= BOOST_MIN_V + BOOST_STEP_V * 5'(boost_q);
		end
	end

	// Write channel: take address and data in any order, then answer.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			awready_q <= 1'b1;
			wready_q <= 1'b1;
			bvalid_q <= 1'b0;
			bresp_q <= RESP_OKAY;
			awaddr_q <= '0;
			wdata_q <= 32'h0;
			wstrb0_q <= 1'b0;
		end else if (clk_en) begin
			if (awvalid && awready_q) begin
				awaddr_q <= awaddr;
				awready_q <= 1'b0;
			end
			if (wvalid && wready_q) begin
				wdata_q <= wdata;
				wstrb0_q <= wstrb[0];
				wready_q <= 1'b0;
			end
			if (wr_fire) begin
				bvalid_q <= 1'b1;
				bresp_q <= wr_hit ? RESP_OKAY : RESP_SLVERR;
			end
			if (bvalid_q && bready) begin
				bvalid_q <= 1'b0;
				awready_q <= 1'b1;
				wready_q <= 1'b1;
			end
		end
	end

	// Writable decode; status is read only.
	always_comb begin
		wr_hit = (awaddr_q == ADDR_MODE) | (awaddr_q == ADDR_BOOST) | (awaddr_q == ADDR_ENABLE);
		for (int k = 0; k < NUM_OUTPUTS; k++) begin
			if (awaddr_q == ADDR_CODE0 + 8'(4 * k)) begin
				wr_hit = 1'b1;
			end
		end
	end

	// Read mux; unmapped addresses read zero.
	always_comb begin
		rd_word = 32'h0;
		rd_hit = 1'b1;
		case (araddr)
			ADDR_MODE: rd_word[MODE_W-1:0] = mode_code_q;
			ADDR_BOOST: rd_word[BOOST_W-1:0] = boost_q;
			ADDR_ENABLE: rd_word[NUM_OUTPUTS-1:0] = enable_q;
			ADDR_STATUS: begin
				rd_word[MODE_W-1:0] = mode_code_q;
				rd_word[STATUS_IO_POS] = io_lvl_q;
				rd_word[STATUS_ANALOG_POS] = an_lvl_q;
			end
			default: rd_hit = 1'b0;
		endcase
		for (int k = 0; k < NUM_OUTPUTS; k++) begin
			if (araddr == ADDR_CODE0 + 8'(4 * k)) begin
				rd_word[CODE_W-1:0] = code_q[k];
				rd_hit = 1'b1;
			end
		end
	end

	// Read channel: answer one cycle after the address is taken.
	always_ff @(posedge aclk) begin
		if (!aresetn) begin
			arready_q <= 1'b1;
			rvalid_q <= 1'b0;
			rdata_q <= 32'h0;
			rresp_q <= RESP_OKAY;
		end else if (clk_en) begin
			if (arvalid && arready_q) begin
				arready_q <= 1'b0;
				rvalid_q <= 1'b1;
				rdata_q <= rd_word;
				rresp_q <= rd_hit ? RESP_OKAY : RESP_SLVERR;
			end else if (rvalid_q && rready) begin
				rvalid_q <= 1'b0;
				arready_q <= 1'b1;
			end
		end
	end

	assign awready = awready_q;
	assign wready = wready_q;
	assign bvalid = bvalid_q;
	assign bresp = bresp_q;
	assign arready = arready_q;
	assign rvalid = rvalid_q;
	assign rdata = rdata_q;
	assign rresp = rresp_q;
	assign power_state_command = mode_code_q;
	assign serial_enable = serial_en_q;
	assign boost_enable = boost_en_q;
	assign boost_code = boost_q;
	assign boosted_rail_volts = rail_q;
	assign out_drive = drive_q;
	assign out_pulldown = pulldown_q;
	assign out_code = code_out_q;

	// Missing supply leads to shutdown next cycle.
	a_supply_loss_shutdown: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_en && !supplies_ok) |=> (mode_q == MODE_SHUTDOWN))
		else $error("Supply loss did not force shutdown.");
	// Shutdown with supplies present moves to startup.
	a_shutdown_to_startup: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_en && supplies_ok && mode_q == MODE_SHUTDOWN) |=> (mode_q == MODE_STARTUP))
		else $error("Shutdown did not move to startup.");
	// Each startup cycle puts boost and enables back to default.
	a_startup_defaults: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_en && mode_q == MODE_STARTUP) |=> (boost_q == RST_BOOST && enable_q == RST_ENABLE))
		else $error("Startup registers not at default.");
	// Last startup count moves to active.
	a_startup_done: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_en && supplies_ok && mode_q == MODE_STARTUP && cnt_q == CNT_W'(STARTUP_LEN - 1))
		|=> (mode_q == MODE_ACTIVE))
		else $error("Startup did not end in active.");
	// Outputs never drive outside active mode.
	a_outputs_float: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_en && mode_q != MODE_ACTIVE) |=> (drive_q == '0 && pulldown_q == '0))
		else $error("Output active outside active mode.");
	// Low power keeps settings.
	a_low_power_keep: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode_q == MODE_LOW_POWER) |=> ($stable(boost_q) && $stable(enable_q)))
		else $error("Setting changed in low power.");
	// Low power is entered only from active.
	a_low_power_entry: assert property (@(posedge aclk) disable iff (!aresetn)
		(mode_q == MODE_LOW_POWER && $past(mode_q) != MODE_LOW_POWER)
		|-> ($past(mode_q) == MODE_ACTIVE))
		else $error("Low power entered from wrong mode.");
	// Rail target follows the boost code.
	a_rail_volts: assert property (@(posedge aclk) disable iff (!aresetn)
		clk_en |=> (rail_q == BOOST_MIN_V + 5'($past(boost_q))))
		else $error("Rail target does not match code.");
	// Disabled zero-code output pulls down.
	a_pulldown_zero: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_en && mode_q == MODE_ACTIVE && !enable_q[0] && code_q[0] == RST_CODE)
		|=> pulldown_q[0] && !drive_q[0])
		else $error("Disabled zero-code output not pulled down.");
	// Boost is off in low power.
	a_boost_off_lp: assert property (@(posedge aclk) disable iff (!aresetn)
		(clk_en && mode_q == MODE_LOW_POWER) |=> !boost_en_q && serial_en_q)
		else $error("Boost or bus wrong in low power.");
endmodule : tbpm_power_ctrl

// ==== tbpm_power_ctrl_tb_top.sv ====
`timescale 1ns/1ps
// Bench for the power-mode controller, with a short startup count.
module tbpm_power_ctrl_tb_top;
	import tbpm_pkg::*;
	localparam int SLEN = 4; // Short startup keeps the run brief.
	logic aclk, aresetn, clk_en, analog_supply, io_supply;
	logic awvalid, awready, wvalid, wready, bvalid, bready;
	logic arvalid, arready, rvalid, rready, serial_enable, boost_enable;
	logic [7:0] awaddr, araddr;
	logic [2:0] awprot, arprot;
	logic [31:0] wdata, rdata, rv;
	logic [3:0] wstrb, boost_code;
	logic [1:0] bresp, rresp, rsp, power_state_command;
	logic [4:0] boosted_rail_volts;
	logic [5:0] out_drive, out_pulldown;
	logic [41:0] out_code, ec;
	// Six codes; with the rail at 28 V the top code keeps a 4 V margin.
	logic [6:0] codes [6] = '{7'h7f, 7'h00, 7'h05, 7'h2a, 7'h40, 7'h11};
	logic [5:0] ens [3] = '{6'h00, 6'h3e, 6'h3c};
	int failures = 0;
	int cmp_count = 0;
	tbpm_power_ctrl #(.STARTUP_LEN(SLEN)) dut (.aclk(aclk), .aresetn(aresetn), .clk_en(clk_en),
		.analog_supply(analog_supply), .io_supply(io_supply), .awvalid(awvalid),
		.awready(awready), .awaddr(awaddr), .awprot(awprot), .wvalid(wvalid), .wready(wready),
		.wdata(wdata), .wstrb(wstrb), .bvalid(bvalid), .bready(bready), .bresp(bresp),
		.arvalid(arvalid), .arready(arready), .araddr(araddr), .arprot(arprot),
		.rvalid(rvalid), .rready(rready), .rdata(rdata), .rresp(rresp),
		.power_state_command(power_state_command), .serial_enable(serial_enable),
		.boost_enable(boost_enable), .boost_code(boost_code),
		.boosted_rail_volts(boosted_rail_volts), .out_drive(out_drive),
		.out_pulldown(out_pulldown), .out_code(out_code));
	tbpm_host_model host (.aclk(aclk), .awvalid(awvalid), .awready(awready), .awaddr(awaddr),
		.awprot(awprot), .wvalid(wvalid), .wready(wready), .wdata(wdata), .wstrb(wstrb),
		.bvalid(bvalid), .bready(bready), .bresp(bresp), .arvalid(arvalid),
		.arready(arready), .araddr(araddr), .arprot(arprot), .rvalid(rvalid),
		.rready(rready), .rdata(rdata), .rresp(rresp));
	// Clock of 100 ns period.
	initial begin
		aclk = 1'b0;
		forever #50 aclk = ~aclk;
	end
	// Compares one value and reports a mismatch.
	task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		cmp_count++;
		if (g !== e) begin
			failures++;
			$display("[FAIL] %s expected %h seen %h", nm, e, g);
		end
	endtask : chk
	// Write that must be answered OKAY.
	task automatic wr_ok(input logic [7:0] a, input logic [31:0] d);
		host.wr(a, d, rsp);
		chk("bresp", {30'h0, RESP_OKAY}, {30'h0, rsp});
		if (host.tmo != 0) stop_test();
		repeat (2) @(negedge aclk);
	endtask : wr_ok
	// Read one register and compare it.
	task automatic rd_chk(input logic [7:0] a, input logic [31:0] e, input string nm);
		host.rd(a, rv, rsp);
		chk(nm, e, rv);
		if (host.tmo != 0) stop_test();
	endtask : rd_chk
	// Waits, bounded, for a mode code to show.
	task automatic wait_mode(input logic [1:0] m);
		int n;
		n = 0;
		while (power_state_command !== m && n < 60) begin
			@(negedge aclk);
			n++;
		end
		chk("mode", {30'h0, m}, {30'h0, power_state_command});
		if (power_state_command !== m) stop_test();
	endtask : wait_mode
	// Prints the counts and the verdict, then ends the run.
	task automatic stop_test();
		failures += host.tmo;
		$display("Comparisons %0d, mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : stop_test
	// Cuts a hang short.
	initial begin
		repeat (20000) @(posedge aclk);
		failures++;
		stop_test();
	end
	// Main sequence.
	initial begin
		{aresetn, analog_supply, io_supply} = 3'b000;
		clk_en = 1'b1;
		repeat (6) @(posedge aclk);
		aresetn <= 1'b1;
		repeat (2) @(negedge aclk);
		chk("shutdown mode", 32'h3, {30'h0, power_state_command});
		chk("shutdown outs", 32'h0, {26'h0, out_drive | out_pulldown});
		chk("shutdown blocks", 32'h0, {31'h0, serial_enable | boost_enable});
		$display("Test shutdown done");
		@(posedge aclk);
		analog_supply <= 1'b1;
		io_supply <= 1'b1;
		wait_mode(CMD_STARTUP);
		chk("startup boost", 32'h1, {31'h0, boost_enable});
		chk("startup outs", 32'h0, {26'h0, out_drive});
		wait_mode(CMD_ACTIVE);
		rd_chk(ADDR_STATUS, 32'hc, "status");
		rd_chk(ADDR_BOOST, {28'h0, RST_BOOST}, "boost default");
		chk("rail default", 32'd24, {27'h0, boosted_rail_volts});
		rd_chk(ADDR_ENABLE, 32'h0, "enable default");
		$display("Test startup done");
		host.lag = 3;
		for (int i = 0; i < 16; i++) begin
			wr_ok(ADDR_BOOST, i);
			chk("rail", 13 + i, {27'h0, boosted_rail_volts});
			chk("boost code", i, {28'h0, boost_code});
		end
		host.lag = 0;
		host.strb = 4'h0;
		wr_ok(ADDR_BOOST, 32'h7);
		host.strb = 4'hf;
		chk("masked write", 32'hf, {28'h0, boost_code});
		for (int k = 0; k < 6; k++) begin
			wr_ok(ADDR_CODE0 + 8'(4 * k), {25'h0, codes[k]});
			ec[7 * k +: 7] = codes[k];
		end
		chk("codes", ec[31:0], out_code[31:0]);
		chk("codes hi", {22'h0, ec[41:32]}, {22'h0, out_code[41:32]});
		for (int j = 0; j < 3; j++) begin
			wr_ok(ADDR_ENABLE, {26'h0, ens[j]});
			chk("drive", {26'h0, ens[j]}, {26'h0, out_drive});
			chk("pulldown", {26'h0, ~ens[j] & 6'h02}, {26'h0, out_pulldown});
		end
		host.rd(8'h28, rv, rsp);
		chk("unmapped data", 32'h0, rv);
		chk("unmapped resp", {30'h0, RESP_SLVERR}, {30'h0, rsp});
		host.wr(ADDR_STATUS, 32'h0, rsp);
		chk("status write", {30'h0, RESP_SLVERR}, {30'h0, rsp});
		$display("Test settings done");
		wr_ok(ADDR_MODE, CMD_LOW_POWER);
		wait_mode(CMD_LOW_POWER);
		chk("lp blocks", 32'h1, {31'h0, serial_enable});
		chk("lp boost", 32'h0, {31'h0, boost_enable});
		chk("lp outs", 32'h0, {26'h0, out_drive | out_pulldown});
		wr_ok(ADDR_BOOST, 32'h3);
		rd_chk(ADDR_BOOST, 32'hf, "lp boost kept");
		wr_ok(ADDR_MODE, CMD_ACTIVE);
		wait_mode(CMD_ACTIVE);
		repeat (2) @(negedge aclk);
		chk("drive kept", 32'h3c, {26'h0, out_drive});
		wr_ok(ADDR_MODE, CODE_SHUTDOWN);
		repeat (4) @(negedge aclk);
		chk("bad command", 32'h0, {30'h0, power_state_command});
		$display("Test low power done");
		wr_ok(ADDR_MODE, CMD_STARTUP);
		wait_mode(CMD_STARTUP);
		wait_mode(CMD_ACTIVE);
		rd_chk(ADDR_ENABLE, 32'h0, "enable reset");
		rd_chk(ADDR_BOOST, 32'hb, "boost reset");
		rd_chk(ADDR_CODE0, 32'h0, "code reset");
		wr_ok(ADDR_BOOST, 32'h5);
		@(posedge aclk);
		io_supply <= 1'b0;
		wait_mode(CODE_SHUTDOWN);
		@(posedge aclk);
		io_supply <= 1'b1;
		wait_mode(CMD_ACTIVE);
		rd_chk(ADDR_BOOST, 32'hb, "boost after off");
		$display("Test reset paths done");
		stop_test();
	end
endmodule : tbpm_power_ctrl_tb_top
